/* src/lcs_device.sv */
// device end: registers link, config and function status for the user logic
// assumes training state, link status, device control and command words
// come from core logic on core_clk, so no synchronisers are needed
`timescale 1ns/1ps
// Contract
// [RULE_01] link down high when LinkUp false
// [RULE_02] link down held zero during reset
// [RULE_03] LinkUp per training state and config path
// [RULE_04] two-bit link progress code
// [RULE_05] width from link status; valid at 11b
// [RULE_06] speed code from link status bits 1:0
// [RULE_07] max payload from device control 7:5
// [RULE_08] user honours max payload both ways; user logic checks transmit payload only
// [RULE_09] max read request from device control 14:12
// [RULE_10] user reads never exceed max read request
// [RULE_11] command enables mirrored, four per function
// [RULE_12] user gates traffic on command enables
// [RULE_13] two status bits per virtual function
// [RULE_14] all outputs registered on user clock
module lcs_device (
   input wire logic core_clk,
   input wire logic rst,
   input wire lcs_pkg::lcs_train_t train_state,
   input wire logic receivers_detected,
   input wire logic dl_init_done,
   input wire logic [15:0] link_status_reg,
   input wire logic [15:0] dev_control_reg,
   input wire logic [15:0] pf_command_reg [lcs_pkg::LCS_NUM_PF],
   input wire logic [lcs_pkg::LCS_NUM_VF-1:0] vf_enabled,
   input wire logic [lcs_pkg::LCS_NUM_VF-1:0] vf_bus_master,
   lcs_if.dev st
);
   lcs_pkg::lcs_train_t prev_state;
   lcs_pkg::lcs_train_t next_prev_state;
   logic via_polling;
   logic next_via_polling;
   logic link_down;
   logic next_link_down;
   logic [1:0] progress;
   logic [1:0] next_progress;
   logic [3:0] width;
   logic [3:0] next_width;
   logic [2:0] speed;
   logic [2:0] next_speed;
   logic [2:0] mps;
   logic [2:0] next_mps;
   logic [2:0] mrrs;
   logic [2:0] next_mrrs;
   logic [7:0] fstat;
   logic [7:0] next_fstat;
   logic [11:0] vfstat;
   logic [11:0] next_vfstat;
   logic link_up;
   logic [lcs_pkg::LCS_BITS_PER_PF-1:0] pf_bits [lcs_pkg::LCS_NUM_PF];
   logic [lcs_pkg::LCS_BITS_PER_VF-1:0] vf_bits [lcs_pkg::LCS_NUM_VF];

   // the packing below is fixed by the interface widths; refuse any other split
   if (lcs_pkg::LCS_NUM_PF * lcs_pkg::LCS_BITS_PER_PF != $bits(fstat)) begin : g_pf_fill_check
      $error("function status packing does not fill its output");
   end
   if (lcs_pkg::LCS_NUM_VF * lcs_pkg::LCS_BITS_PER_VF != $bits(vfstat)) begin : g_vf_fill_check
      $error("virtual function packing does not fill its output");
   end
   if (lcs_pkg::LCS_BITS_PER_PF != 4) begin : g_pf_bits_check
      $error("each function carries exactly four command enables");
   end
   if (lcs_pkg::LCS_BITS_PER_VF != 2) begin : g_vf_bits_check
      $error("each virtual function carries exactly two status bits");
   end

   // configuration reached straight from polling keeps LinkUp false
   always_comb begin
      next_prev_state = train_state;
      next_via_polling = via_polling;
      if (train_state == lcs_pkg::LCS_TS_POLLING) begin
         next_via_polling = 1'b1;
      end else if (train_state != lcs_pkg::LCS_TS_CONFIG) begin
         next_via_polling = 1'b0;
      end else if (prev_state != lcs_pkg::LCS_TS_CONFIG && prev_state != lcs_pkg::LCS_TS_POLLING) begin
         next_via_polling = 1'b0; // RULE_03
      end
   end

   // detect and polling fall to the default: no link yet
   always_comb begin
      case (train_state)
         lcs_pkg::LCS_TS_RECOVERY,
         lcs_pkg::LCS_TS_L0,
         lcs_pkg::LCS_TS_L0S,
         lcs_pkg::LCS_TS_L1,
         lcs_pkg::LCS_TS_L2: link_up = 1'b1; // RULE_03
         lcs_pkg::LCS_TS_CONFIG: link_up = !next_via_polling; // RULE_03
         default: link_up = 1'b0;
      endcase
   end

   // missing receivers outrank training, so a pulled cable reads as no receivers
   always_comb begin
      next_link_down = !link_up; // RULE_01
      if (!receivers_detected) begin
         next_progress = lcs_pkg::LCS_PROG_NO_RX; // RULE_04
      end else if (!link_up) begin
         next_progress = lcs_pkg::LCS_PROG_TRAINING; // RULE_04
      end else if (!dl_init_done) begin
         next_progress = lcs_pkg::LCS_PROG_DL_INIT; // RULE_04
      end else begin
         next_progress = lcs_pkg::LCS_PROG_DL_DONE; // RULE_04
      end
   end

   // field copies plus the speed decode; width is not qualified here, the user end gates it by progress
   always_comb begin
      next_width = link_status_reg[lcs_pkg::LCS_LSTAT_WIDTH_LSB +: 4]; // RULE_05
      case (link_status_reg[lcs_pkg::LCS_LSTAT_SPEED_LSB +: 2])
         2'h1: next_speed = lcs_pkg::LCS_SPEED_2G5; // RULE_06
         2'h2: next_speed = lcs_pkg::LCS_SPEED_5G0; // RULE_06
         2'h3: next_speed = lcs_pkg::LCS_SPEED_8G0; // RULE_06
         default: next_speed = lcs_pkg::LCS_SPEED_NONE;
      endcase
      next_mps = dev_control_reg[lcs_pkg::LCS_DCTL_MPS_LSB +: 3]; // RULE_07
      next_mrrs = dev_control_reg[lcs_pkg::LCS_DCTL_MRRS_LSB +: 3]; // RULE_09
   end

   // one slice of command enables per physical function, io enable lowest
   for (genvar f = 0; f < lcs_pkg::LCS_NUM_PF; f++) begin : g_pf
      assign pf_bits[f] = {pf_command_reg[f][lcs_pkg::LCS_CMD_INTX_DIS_BIT],
         pf_command_reg[f][lcs_pkg::LCS_CMD_BM_BIT],
         pf_command_reg[f][lcs_pkg::LCS_CMD_MEM_BIT],
         pf_command_reg[f][lcs_pkg::LCS_CMD_IO_BIT]}; // RULE_11
   end

   // one pair of status bits per virtual function, enable in the lower bit
   for (genvar v = 0; v < lcs_pkg::LCS_NUM_VF; v++) begin : g_vf
      assign vf_bits[v] = {vf_bus_master[v], vf_enabled[v]}; // RULE_13
   end

   always_comb begin
      next_fstat = '0;
      next_vfstat = '0;
      for (int f = 0; f < lcs_pkg::LCS_NUM_PF; f++) begin
         next_fstat[f*lcs_pkg::LCS_BITS_PER_PF +: lcs_pkg::LCS_BITS_PER_PF] = pf_bits[f]; // RULE_11
      end
      for (int v = 0; v < lcs_pkg::LCS_NUM_VF; v++) begin
         next_vfstat[v*lcs_pkg::LCS_BITS_PER_VF +: lcs_pkg::LCS_BITS_PER_VF] = vf_bits[v]; // RULE_13
      end
   end

   // configuration path tracker; reset as if training starts from detect
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prev_state <= lcs_pkg::LCS_TS_DETECT;
         via_polling <= 1'b0;
      end else begin
         prev_state <= next_prev_state;
         via_polling <= next_via_polling;
      end
   end

   // every output is a flop so user logic may sample without synchronising
   // link down resets to zero, not to the level an idle link would show
   always_ff @(posedge core_clk) begin
      if (rst) begin
         link_down <= lcs_pkg::LCS_LINK_DOWN_RST; // RULE_02
         progress <= lcs_pkg::LCS_PROG_NO_RX;
      end else begin
         link_down <= next_link_down; // RULE_14
         progress <= next_progress; // RULE_14
      end
   end

   // copied fields lag their source registers by one clock
   always_ff @(posedge core_clk) begin
      if (rst) begin
         width <= '0;
         speed <= lcs_pkg::LCS_SPEED_NONE;
         mps <= '0;
         mrrs <= '0;
      end else begin
         width <= next_width; // RULE_14
         speed <= next_speed; // RULE_14
         mps <= next_mps; // RULE_14
         mrrs <= next_mrrs; // RULE_14
      end
   end

   // function enables; software writes land here one clock after the command word
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fstat <= '0;
         vfstat <= '0;
      end else begin
         fstat <= next_fstat; // RULE_14
         vfstat <= next_vfstat; // RULE_14
      end
   end

   assign st.link_down = link_down;
   assign st.link_progress = progress;
   assign st.negotiated_width = width;
   assign st.current_speed = speed;
   assign st.max_payload = mps;
   assign st.max_read_req = mrrs;
   assign st.function_status = fstat;
   assign st.virtual_function_state_bits = vfstat;
endmodule : lcs_device

/* src/lcs_pkg.sv */
// package for the link status output group: codes, field positions, widths
// assumes both ends run on the same user clock and synchronous reset
package lcs_pkg;
   // training states as seen by the device end
   typedef enum logic [3:0] {
      LCS_TS_DETECT = 4'h0,
      LCS_TS_POLLING = 4'h1,
      LCS_TS_CONFIG = 4'h3,
      LCS_TS_L0 = 4'h2,
      LCS_TS_RECOVERY = 4'h6,
      LCS_TS_L0S = 4'h7,
      LCS_TS_L1 = 4'h5,
      LCS_TS_L2 = 4'h4
   } lcs_train_t;

   localparam logic [1:0] LCS_PROG_NO_RX = 2'h0;
   localparam logic [1:0] LCS_PROG_TRAINING = 2'h1;
   localparam logic [1:0] LCS_PROG_DL_INIT = 2'h2;
   localparam logic [1:0] LCS_PROG_DL_DONE = 2'h3;

   localparam logic [2:0] LCS_SPEED_2G5 = 3'h1;
   localparam logic [2:0] LCS_SPEED_5G0 = 3'h2;
   localparam logic [2:0] LCS_SPEED_8G0 = 3'h4;
   localparam logic [2:0] LCS_SPEED_NONE = 3'h0;

   localparam int LCS_LSTAT_SPEED_LSB = 0;
   localparam int LCS_LSTAT_WIDTH_LSB = 4;
   localparam int LCS_DCTL_MPS_LSB = 5;
   localparam int LCS_DCTL_MRRS_LSB = 12;
   localparam int LCS_CMD_IO_BIT = 0;
   localparam int LCS_CMD_MEM_BIT = 1;
   localparam int LCS_CMD_BM_BIT = 2;
   localparam int LCS_CMD_INTX_DIS_BIT = 10;

   localparam int LCS_NUM_PF = 2;
   localparam int LCS_NUM_VF = 6;
   localparam int LCS_BITS_PER_PF = 4;
   localparam int LCS_BITS_PER_VF = 2;
   localparam logic [2:0] LCS_SIZE_MAX = 3'h5;

   localparam logic LCS_LINK_DOWN_RST = 1'b0;
endpackage : lcs_pkg

/* src/lcs_if.sv */
// interface joining the device status outputs to the user logic
// assumes one shared clock; all signals are registered by the device end
`timescale 1ns/1ps
interface lcs_if;
   logic link_down;
   logic [1:0] link_progress;
   logic [3:0] negotiated_width;
   logic [2:0] current_speed;
   logic [2:0] max_payload;
   logic [2:0] max_read_req;
   logic [7:0] function_status;
   logic [11:0] virtual_function_state_bits;

   modport dev (output link_down, link_progress, negotiated_width, current_speed,
      max_payload, max_read_req, function_status, virtual_function_state_bits);
   modport usr (input link_down, link_progress, negotiated_width, current_speed,
      max_payload, max_read_req, function_status, virtual_function_state_bits);
endinterface : lcs_if

/* src/lcs_user.sv */
// user end: turns status outputs into size limits and per-function permissions
// assumes the device end registers every signal on the same core_clk
`timescale 1ns/1ps
module lcs_user (
   input wire logic core_clk,
   input wire logic rst,
   lcs_if.usr st,
   input wire logic [12:0] tx_payload_bytes,
   input wire logic [12:0] rd_req_bytes,
   input wire logic [lcs_pkg::LCS_NUM_PF-1:0] tx_func_sel,
   output logic link_ready,
   output logic [3:0] link_width,
   output logic [12:0] payload_limit,
   output logic [12:0] read_limit,
   output logic tx_allowed,
   output logic rd_allowed,
   output logic [lcs_pkg::LCS_NUM_PF-1:0] mem_enabled
);
   logic next_ready;
   logic [3:0] next_width;
   logic [12:0] next_pl;
   logic [12:0] next_rl;
   logic next_tx;
   logic next_rd;
   logic [lcs_pkg::LCS_NUM_PF-1:0] next_mem;
   logic [lcs_pkg::LCS_NUM_PF-1:0] bm;
   logic sel_bm;

   function automatic logic [12:0] lcs_size_bytes(input logic [2:0] code);
      logic [2:0] c;
      c = (code > lcs_pkg::LCS_SIZE_MAX) ? lcs_pkg::LCS_SIZE_MAX : code;
      return 13'h0080 << c;
   endfunction : lcs_size_bytes

   always_comb begin
      next_ready = (st.link_progress == lcs_pkg::LCS_PROG_DL_DONE) && !st.link_down;
      next_width = next_ready ? st.negotiated_width : 4'h0; // RULE_05
      next_pl = lcs_size_bytes(st.max_payload);
      next_rl = lcs_size_bytes(st.max_read_req);
      for (int f = 0; f < lcs_pkg::LCS_NUM_PF; f++) begin
         next_mem[f] = st.function_status[f*lcs_pkg::LCS_BITS_PER_PF + 1]; // RULE_12
         bm[f] = st.function_status[f*lcs_pkg::LCS_BITS_PER_PF + 2]; // RULE_12
      end
      sel_bm = |(bm & tx_func_sel);
      next_tx = next_ready && sel_bm && (tx_payload_bytes <= next_pl); // RULE_08
      next_rd = next_ready && sel_bm && (rd_req_bytes <= next_rl); // RULE_10
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         link_ready <= 1'b0;
         link_width <= '0;
         payload_limit <= '0;
         read_limit <= '0;
         tx_allowed <= 1'b0;
         rd_allowed <= 1'b0;
         mem_enabled <= '0;
      end else begin
         link_ready <= next_ready;
         link_width <= next_width;
         payload_limit <= next_pl;
         read_limit <= next_rl;
         tx_allowed <= next_tx;
         rd_allowed <= next_rd;
         mem_enabled <= next_mem;
      end
   end
endmodule : lcs_user

/* testbench/lcs_checker.sv */
// checker on the status interface signals and the device inputs
// assumes one clock; placed beside the interface by the bench top
`timescale 1ns/1ps
module lcs_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire lcs_pkg::lcs_train_t train_state,
   input wire logic receivers_detected,
   input wire logic dl_init_done,
   input wire logic [15:0] link_status_reg,
   input wire logic [15:0] dev_control_reg,
   input wire logic link_down,
   input wire logic [1:0] link_progress,
   input wire logic [3:0] negotiated_width,
   input wire logic [2:0] current_speed,
   input wire logic [2:0] max_payload,
   input wire logic [2:0] max_read_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic up_st;
   logic [3:0] w_in;
   logic [2:0] spd_exp;
   logic [5:0] sz_in;
   assign up_st = train_state inside {lcs_pkg::LCS_TS_L0, lcs_pkg::LCS_TS_L0S, lcs_pkg::LCS_TS_L1,
      lcs_pkg::LCS_TS_L2, lcs_pkg::LCS_TS_RECOVERY};
   assign w_in = link_status_reg[7:4];
   assign spd_exp = (link_status_reg[1:0] == 2'h1) ? 3'h1 : (link_status_reg[1:0] == 2'h2) ? 3'h2 :
      (link_status_reg[1:0] == 2'h3) ? 3'h4 : 3'h0;
   assign sz_in = {dev_control_reg[7:5], dev_control_reg[14:12]};
   up_state_a: assert property (up_st |=> !link_down)
      else $error("link down high while link is up");
   down_state_a: assert property (train_state inside {lcs_pkg::LCS_TS_DETECT, lcs_pkg::LCS_TS_POLLING} |=> link_down)
      else $error("link down low before configuration");
   cfg_from_poll_a: assert property (train_state == lcs_pkg::LCS_TS_POLLING ##1 train_state == lcs_pkg::LCS_TS_CONFIG |=> link_down)
      else $error("link down low in configuration entered from polling");
   reset_zero_a: assert property ($fell(rst) |-> !link_down && link_progress == 2'h0)
      else $error("outputs not zero on reset release");
   prog_done_a: assert property (up_st && receivers_detected && dl_init_done |=> link_progress == 2'h3)
      else $error("progress not done");
   prog_train_a: assert property (receivers_detected && train_state == lcs_pkg::LCS_TS_POLLING |=> link_progress == 2'h1)
      else $error("progress not training");
   prog_norx_a: assert property (!receivers_detected && train_state == lcs_pkg::LCS_TS_DETECT |=> link_progress == 2'h0)
      else $error("progress not idle");
   width_copy_a: assert property (1'b1 |=> negotiated_width == $past(w_in))
      else $error("width not copied");
   speed_code_a: assert property (1'b1 |=> current_speed == $past(spd_exp))
      else $error("speed code wrong");
   size_copy_a: assert property (1'b1 |=> {max_payload, max_read_req} == $past(sz_in))
      else $error("size codes wrong");
   cover property (link_progress == 2'h3);
   cover property ($rose(link_down));
   cover property (current_speed == 3'h4);
endmodule : lcs_checker

/* testbench/link_config_status_outputs_test.sv */
// bench: device and user ends joined by the status interface
// assumes 40 MHz core_clk and synchronous active-high rst
`timescale 1ns/1ps
module link_config_status_outputs_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   lcs_pkg::lcs_train_t train_state = lcs_pkg::LCS_TS_DETECT;
   logic receivers_detected = 1'b0;
   logic dl_init_done = 1'b0;
   logic [15:0] link_status_reg = 16'h0000;
   logic [15:0] dev_control_reg = 16'h0000;
   logic [15:0] pf_command_reg [lcs_pkg::LCS_NUM_PF] = '{16'h0000, 16'h0000};
   logic [5:0] vf_enabled = 6'h00;
   logic [5:0] vf_bus_master = 6'h00;
   logic [12:0] tx_payload_bytes = 13'h0000;
   logic [12:0] rd_req_bytes = 13'h0000;
   logic [1:0] tx_func_sel = 2'h1;
   logic link_ready, tx_allowed, rd_allowed;
   logic [3:0] link_width;
   logic [12:0] payload_limit, read_limit;
   logic [1:0] mem_enabled;
   logic [11:0] vexp;
   logic [2:0] spd [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   lcs_pkg::lcs_train_t ups [4] = '{lcs_pkg::LCS_TS_L0S, lcs_pkg::LCS_TS_L1, lcs_pkg::LCS_TS_L2,
      lcs_pkg::LCS_TS_RECOVERY};
   int miscompares = 0;
   int n_checks = 0;
   always #12.5 core_clk = ~core_clk;
   lcs_if u_lcs_if ();
   lcs_device u_lcs_device (.core_clk(core_clk), .rst(rst), .train_state(train_state),
      .receivers_detected(receivers_detected), .dl_init_done(dl_init_done), .link_status_reg(link_status_reg),
      .dev_control_reg(dev_control_reg), .pf_command_reg(pf_command_reg), .vf_enabled(vf_enabled),
      .vf_bus_master(vf_bus_master), .st(u_lcs_if));
   lcs_user u_lcs_user (.core_clk(core_clk), .rst(rst), .st(u_lcs_if), .tx_payload_bytes(tx_payload_bytes),
      .rd_req_bytes(rd_req_bytes), .tx_func_sel(tx_func_sel), .link_ready(link_ready), .link_width(link_width),
      .payload_limit(payload_limit), .read_limit(read_limit), .tx_allowed(tx_allowed),
      .rd_allowed(rd_allowed), .mem_enabled(mem_enabled));
   lcs_checker u_lcs_checker (.core_clk(core_clk), .rst(rst), .train_state(train_state),
      .receivers_detected(receivers_detected), .dl_init_done(dl_init_done), .link_status_reg(link_status_reg),
      .dev_control_reg(dev_control_reg), .link_down(u_lcs_if.link_down), .link_progress(u_lcs_if.link_progress),
      .negotiated_width(u_lcs_if.negotiated_width), .current_speed(u_lcs_if.current_speed),
      .max_payload(u_lcs_if.max_payload), .max_read_req(u_lcs_if.max_read_req));
   task automatic ck(input string what, input logic [12:0] exp, input logic [12:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : ck
   // three edges cover the device stage plus the user stage
   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic link(input lcs_pkg::lcs_train_t ts, input logic rx, input logic dl);
      @(posedge core_clk);
      train_state <= ts;
      receivers_detected <= rx;
      dl_init_done <= dl;
      settle();
   endtask : link
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #1ms;
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (11) @(posedge core_clk);
      #1;
      ck("reset down", 13'h0000, 13'(u_lcs_if.link_down));
      @(posedge core_clk);
      rst <= 1'b0;
      settle();
      ck("detect down", 13'h0001, 13'(u_lcs_if.link_down));
      ck("no rx", 13'h0000, 13'(u_lcs_if.link_progress));
      link(lcs_pkg::LCS_TS_POLLING, 1'b1, 1'b0);
      ck("training", 13'h0001, 13'(u_lcs_if.link_progress));
      link(lcs_pkg::LCS_TS_CONFIG, 1'b1, 1'b0);
      ck("cfg from poll", 13'h0001, 13'(u_lcs_if.link_down));
      link(lcs_pkg::LCS_TS_L0, 1'b1, 1'b0);
      ck("dl init", 13'h0002, 13'(u_lcs_if.link_progress));
      ck("not ready", 13'h0000, 13'(link_ready));
      for (int k = 0; k < 4; k++) begin
         link(ups[k], 1'b1, 1'b0);
         ck("up state", 13'h0000, 13'(u_lcs_if.link_down));
      end
      link(lcs_pkg::LCS_TS_CONFIG, 1'b1, 1'b0);
      ck("cfg from recovery", 13'h0000, 13'(u_lcs_if.link_down));
      link(lcs_pkg::LCS_TS_L0, 1'b1, 1'b1);
      ck("dl done", 13'h0003, 13'(u_lcs_if.link_progress));
      ck("ready", 13'h0001, 13'(link_ready));
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         link_status_reg <= {8'h00, 4'(k + 1), 2'h0, 2'(k)};
         settle();
         ck("speed", 13'(spd[k]), 13'(u_lcs_if.current_speed));
         ck("width", 13'(k + 1), 13'(u_lcs_if.negotiated_width));
         ck("user width", 13'(k + 1), 13'(link_width));
      end
      for (int k = 0; k < 8; k++) begin
         @(posedge core_clk);
         dev_control_reg <= {1'b0, 3'(7 - k), 4'h0, 3'(k), 5'h00};
         settle();
         ck("mps", 13'(k), 13'(u_lcs_if.max_payload));
         ck("mrrs", 13'(7 - k), 13'(u_lcs_if.max_read_req));
         ck("pay lim", 13'(128 << (k > 5 ? 5 : k)), payload_limit);
         ck("rd lim", 13'(128 << (7 - k > 5 ? 5 : 7 - k)), read_limit);
      end
      @(posedge core_clk);
      pf_command_reg <= '{16'h0405, 16'h0002};
      vf_enabled <= 6'h29;
      vf_bus_master <= 6'h0C;
      tx_payload_bytes <= 13'h1000;
      rd_req_bytes <= 13'h0081;
      settle();
      for (int v = 0; v < 6; v++) vexp[2 * v +: 2] = {vf_bus_master[v], vf_enabled[v]};
      ck("func status", 13'h002D, 13'(u_lcs_if.function_status));
      ck("vf bits", 13'(vexp), 13'(u_lcs_if.virtual_function_state_bits));
      ck("mem en", 13'h0002, 13'(mem_enabled));
      ck("tx at lim", 13'h0001, 13'(tx_allowed));
      ck("rd over", 13'h0000, 13'(rd_allowed));
      @(posedge core_clk);
      tx_payload_bytes <= 13'h1001;
      rd_req_bytes <= 13'h0080;
      settle();
      ck("tx over", 13'h0000, 13'(tx_allowed));
      ck("rd at lim", 13'h0001, 13'(rd_allowed));
      @(posedge core_clk);
      tx_func_sel <= 2'h2;
      tx_payload_bytes <= 13'h0080;
      settle();
      ck("tx no bm", 13'h0000, 13'(tx_allowed));
      give_verdict();
   end
endmodule : link_config_status_outputs_test
